//--- rfs_fault_irq.sv
//==============================================================
// Purpose: Fault status, interrupt pin, stop packets, I2C target
// Assumes: Pins async to clk_i; thermistor codes already scaled
// Notes: Interrupt pin open drain, driven low when asserted
//==============================================================
`timescale 1ns/1ps
module rfs_fault_irq import rfs_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fault sources (pins)
	input wire logic disable_i,
	input wire logic charge_done_i,
	input wire logic die_shutdown_i,
	input wire logic [7:0] die_temp_c_i,
	input wire logic remote_temp_a_over_i,
	input wire logic remote_temp_b_over_i,
	// Thermistor ADC codes, same clock
	input wire logic [7:0] remote_temp_input_a_i,
	input wire logic [7:0] remote_temp_input_b_i,
	// Power stop packet request
	output logic power_stop_packet_o,
	output logic [7:0] power_stop_code_o,
	// Interrupt open drain
	output logic irq_n_o,
	output logic irq_oe_o,
	// I2C pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	//==========================================================
	// Input synchronisers
	logic [6:0] s1_q, s2_q, s3_q;
	logic [7:0] dt1_q, dt2_q, dt3_q;
	// Bus lines idle high, fault pins idle low: no false edge after reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_q <= 7'h60;
			s2_q <= 7'h60;
			s3_q <= 7'h60;
			dt1_q <= 8'h00;
			dt2_q <= 8'h00;
			dt3_q <= 8'h00;
		end else begin
			s1_q <= {scl_i, sda_i, remote_temp_b_over_i, remote_temp_a_over_i, die_shutdown_i, charge_done_i, disable_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			dt1_q <= die_temp_c_i;
			dt2_q <= dt1_q;
			dt3_q <= dt2_q;
		end
	end
	logic scl_s, sda_s, scl_p, sda_p;
	assign scl_s = s2_q[6];
	assign sda_s = s2_q[5];
	assign scl_p = s3_q[6];
	assign sda_p = s3_q[5];

	//==========================================================
	// Raw and masked fault status
	logic [7:0] raw_d, raw_q, fen_q, ien_q, mf, mi;
	always_comb begin
		raw_d = 8'h00;
		raw_d[RFS_B_TSB] = s2_q[4];
		raw_d[RFS_B_TSA] = s2_q[3];
		// Temperature word trusted only once two samples agree
		raw_d[RFS_B_DIE] = s2_q[2] | ((dt2_q == dt3_q) ? (dt2_q >= RFS_DIE_LIMIT_C) : raw_q[RFS_B_DIE]);
		raw_d[RFS_B_DONE] = s2_q[1];
		raw_d[RFS_B_DIS] = s2_q[0];
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) raw_q <= 8'h00;
		else raw_q <= raw_d & RFS_FAULT_MASK;
	end
	assign mf = raw_q & fen_q & RFS_FAULT_MASK;
	assign mi = raw_q & ien_q & RFS_FAULT_MASK;

	// Interrupt pin pulled low while any enabled fault
	always_comb begin
		irq_oe_o = |mi;
		irq_n_o = 1'b0;
	end

	//==========================================================
	// Stop packet on rising masked fault
	logic [7:0] mf_prev_q;
	logic pkt_d, pkt_q;
	logic [7:0] code_d, code_q;
	always_comb begin
		logic [7:0] rise;
		rise = mf & ~mf_prev_q;
		pkt_d = |rise;
		code_d = code_q;
		if (rise[RFS_B_TSB] | rise[RFS_B_TSA]) code_d = RFS_PKT_THERM;
		else if (rise[RFS_B_DIE] | rise[RFS_B_DIS]) code_d = RFS_PKT_HEAT;
		else if (rise[RFS_B_DONE]) code_d = RFS_PKT_DONE;
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			mf_prev_q <= 8'h00;
			pkt_q <= 1'b0;
			code_q <= 8'h00;
		end else begin
			mf_prev_q <= mf;
			pkt_q <= pkt_d;
			code_q <= code_d;
		end
	end
	assign power_stop_packet_o = pkt_q;
	assign power_stop_code_o = code_q;

	//==========================================================
	// I2C target
	rfs_state_t st_q, st_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_byte;
	logic [3:0] cnt_q, cnt_d;
	logic ptr_set_q, ptr_set_d, sda_oe_q, sda_oe_d, rnw_q, rnw_d;
	logic [7:0] fen_d, ien_d, part_hi_q, part_hi_d, part_lo_q, part_lo_d;
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_c = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_c = scl_s & scl_p & ~sda_p & sda_s;

	// Readback mux
	always_comb begin
		unique case (ptr_q)
			RFS_A_FEN_LO: rd_byte = fen_q;
			RFS_A_IEN_LO: rd_byte = ien_q;
			RFS_A_TS_A: rd_byte = remote_temp_input_a_i;
			RFS_A_TS_B: rd_byte = remote_temp_input_b_i;
			RFS_A_RAW_LO: rd_byte = raw_q;
			RFS_A_MF_LO: rd_byte = mf;
			RFS_A_MI_LO: rd_byte = mi;
			RFS_A_PART_HI: rd_byte = part_hi_q;
			RFS_A_PART_LO: rd_byte = part_lo_q;
			RFS_A_FW: rd_byte = RFS_FW_VALUE;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		ptr_set_d = ptr_set_q;
		sda_oe_d = sda_oe_q;
		rnw_d = rnw_q;
		fen_d = fen_q;
		ien_d = ien_q;
		part_hi_d = part_hi_q;
		part_lo_d = part_lo_q;
		if (start_c) begin
			st_d = RFS_ADDR;
			cnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end else if (stop_c) begin
			st_d = RFS_IDLE;
			sda_oe_d = 1'b0;
		end else begin
			unique case (st_q)
				RFS_IDLE: ;
				RFS_ADDR, RFS_WR: if (scl_rise) begin
					sh_d = {sh_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
				end else if (scl_fall && cnt_q == 4'h8) begin
					cnt_d = 4'h0;
					if (st_q == RFS_ADDR) begin
						if (sh_q[7:1] == RFS_I2C_ADDR) begin
							rnw_d = sh_q[0];
							ptr_set_d = 1'b0;
							sda_oe_d = 1'b1;
							st_d = RFS_AACK;
						end else st_d = RFS_IDLE;
					end else begin
						sda_oe_d = 1'b1;
						st_d = RFS_WACK;
						if (!ptr_set_q) begin
							ptr_d = sh_q;
							ptr_set_d = 1'b1;
						end else begin
							unique case (ptr_q)
								RFS_A_FEN_LO: fen_d = sh_q & RFS_FAULT_MASK;
								RFS_A_IEN_LO: ien_d = sh_q & RFS_FAULT_MASK;
								RFS_A_PART_HI: part_hi_d = sh_q;
								RFS_A_PART_LO: part_lo_d = sh_q;
								default: ;
							endcase
							ptr_d = ptr_q + 8'h01;
						end
					end
				end
				RFS_AACK, RFS_WACK: if (scl_fall) begin
					if (st_q == RFS_AACK && rnw_q) begin
						sh_d = rd_byte;
						sda_oe_d = ~rd_byte[7];
						cnt_d = 4'h1;
						st_d = RFS_RD;
					end else begin
						sda_oe_d = 1'b0;
						st_d = RFS_WR;
					end
				end
				RFS_RD: if (scl_fall) begin
					if (cnt_q == 4'h8) begin
						sda_oe_d = 1'b0;
						ptr_d = ptr_q + 8'h01;
						st_d = RFS_RACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						sda_oe_d = ~sh_q[6];
						cnt_d = cnt_q + 4'h1;
					end
				end
				RFS_RACK: if (scl_rise) begin
					if (sda_s) st_d = RFS_IDLE;
					else st_d = RFS_AACK;
				end
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= RFS_IDLE;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 4'h0;
			ptr_set_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rnw_q <= 1'b0;
			fen_q <= RFS_EN_RST & RFS_FAULT_MASK;
			ien_q <= RFS_EN_RST & RFS_FAULT_MASK;
			part_hi_q <= RFS_PART_HI_RST;
			part_lo_q <= RFS_PART_LO_RST;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			ptr_set_q <= ptr_set_d;
			sda_oe_q <= sda_oe_d;
			rnw_q <= rnw_d;
			fen_q <= fen_d;
			ien_q <= ien_d;
			part_hi_q <= part_hi_d;
			part_lo_q <= part_lo_d;
		end
	end
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_q;

	//==========================================================
	// Assertions
	sequence seq_done_raw;
		s2_q[1] && fen_q[RFS_B_DONE] && !mf_prev_q[RFS_B_DONE];
	endsequence
	AST_IRQ_ON: assert property (@(posedge clk_i) disable iff (!rst_n_i) (s2_q[0] && ien_q[RFS_B_DIS]) |=> (irq_oe_o || !ien_q[RFS_B_DIS]))
		else $error("interrupt not asserted");
	AST_IRQ_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i) (raw_q == 8'h00) |-> !irq_oe_o)
		else $error("interrupt asserted without fault");
	AST_RAW_FOLLOW: assert property (@(posedge clk_i) disable iff (!rst_n_i) s2_q[0] |=> raw_q[RFS_B_DIS])
		else $error("raw disable bit not set");
	AST_RAW_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n_i) (raw_q & ~RFS_FAULT_MASK) == 8'h00)
		else $error("reserved raw bit set");
	AST_MF_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i) mf[RFS_B_TSA] |-> fen_q[RFS_B_TSA] && $past(s2_q[3]))
		else $error("masked fault without enable");
	AST_MI_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i) !ien_q[RFS_B_DIE] |-> !mi[RFS_B_DIE])
		else $error("masked irq without enable");
	AST_DONE_PKT: assert property (@(posedge clk_i) disable iff (!rst_n_i) seq_done_raw |-> ##[1:2] power_stop_packet_o)
		else $error("no stop packet on charge done");
	AST_THERM_CODE: assert property (@(posedge clk_i) disable iff (!rst_n_i) (mf[RFS_B_TSB] && !mf_prev_q[RFS_B_TSB]) |=> power_stop_packet_o && power_stop_code_o == RFS_PKT_THERM)
		else $error("wrong thermistor code");
	AST_NO_PKT_DIS: assert property (@(posedge clk_i) disable iff (!rst_n_i) (mf == 8'h00) |=> !power_stop_packet_o)
		else $error("packet with no enabled fault");
endmodule // rfs_fault_irq

//--- rfs_pkg.sv
//==============================================================
// Purpose: Constants for the receiver fault/status/interrupt block
// Assumes: 200 MHz clk_i, synchronous active-low reset
// Notes: Register addresses are byte addresses on the I2C target
//==============================================================
package rfs_pkg;
	localparam logic [6:0] RFS_I2C_ADDR = 7'h68;
	localparam logic [7:0] RFS_A_FEN_HI = 8'h00;
	localparam logic [7:0] RFS_A_FEN_LO = 8'h01;
	localparam logic [7:0] RFS_A_IEN_HI = 8'h02;
	localparam logic [7:0] RFS_A_IEN_LO = 8'h03;
	localparam logic [7:0] RFS_A_TS_A = 8'h10;
	localparam logic [7:0] RFS_A_TS_B = 8'h11;
	localparam logic [7:0] RFS_A_RAW_HI = 8'hd4;
	localparam logic [7:0] RFS_A_RAW_LO = 8'hd5;
	localparam logic [7:0] RFS_A_MF_HI = 8'hd6;
	localparam logic [7:0] RFS_A_MF_LO = 8'hd7;
	localparam logic [7:0] RFS_A_MI_HI = 8'hd8;
	localparam logic [7:0] RFS_A_MI_LO = 8'hd9;
	localparam logic [7:0] RFS_A_PART_HI = 8'hfc;
	localparam logic [7:0] RFS_A_PART_LO = 8'hfd;
	localparam logic [7:0] RFS_A_FW = 8'hff;
	// Implemented fault bits in low byte
	localparam int RFS_B_TSB = 7;
	localparam int RFS_B_TSA = 6;
	localparam int RFS_B_DIE = 5;
	localparam int RFS_B_DONE = 2;
	localparam int RFS_B_DIS = 0;
	localparam logic [7:0] RFS_FAULT_MASK = 8'he5;
	localparam logic [7:0] RFS_EN_RST = 8'hff;
	// Identification, values arbitrary
	localparam logic [7:0] RFS_PART_HI_RST = 8'h5a;
	localparam logic [7:0] RFS_PART_LO_RST = 8'h3c;
	localparam logic [7:0] RFS_FW_VALUE = 8'h11;
	// Stop packet codes
	localparam logic [7:0] RFS_PKT_DONE = 8'h01;
	localparam logic [7:0] RFS_PKT_HEAT = 8'h02;
	localparam logic [7:0] RFS_PKT_THERM = 8'h03;
	// Die limit in degrees C
	localparam logic [7:0] RFS_DIE_LIMIT_C = 8'd130;
	typedef enum logic [2:0] {RFS_IDLE, RFS_ADDR, RFS_AACK, RFS_WR, RFS_WACK, RFS_RD, RFS_RACK} rfs_state_t;
endpackage

//--- rfs_host.sv
//==============================================================
// Purpose: I2C host model reaching the register target
// Assumes: Open-drain lines with pull-ups
// Notes: Six clocks per bus phase
//==============================================================
`timescale 1ns/1ps
module rfs_host import rfs_pkg::*; (
	// Clock and bus
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	// Lines released at start
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	// One bus phase, held for six clocks
	task automatic ph(input logic scl, input logic oe);
		scl_o <= scl;
		sda_oe_o <= oe;
		repeat (6) @(posedge clk_i);
	endtask
	// Start, also repeated start
	task automatic start;
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
	endtask
	task automatic stop;
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask
	// Data held across the whole clock pulse
	task automatic bitx(input logic b, output logic r);
		ph(1'b0, !b);
		ph(1'b1, !b);
		r = sda_i;
		ph(1'b0, !b);
	endtask
	// Byte MSB first, then acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(tx[i], r);
			rx[i] = r;
		end
		bitx(last, r);
		ack = !r;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic k1, k2, k3;
		start;
		xfer({RFS_I2C_ADDR, 1'b0}, 1'b1, rx, k1);
		xfer(a, 1'b1, rx, k2);
		xfer(d, 1'b1, rx, k3);
		stop;
		ok = k1 & k2 & k3;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic k1, k2, k3, k4;
		start;
		xfer({RFS_I2C_ADDR, 1'b0}, 1'b1, rx, k1);
		xfer(a, 1'b1, rx, k2);
		start;
		xfer({RFS_I2C_ADDR, 1'b1}, 1'b1, rx, k3);
		xfer(8'hff, 1'b1, d, k4);
		stop;
		// Target must let go of SDA in the closing not-acknowledge slot
		ok = k1 & k2 & k3 & !k4;
	endtask
endmodule // rfs_host

//--- tb_rfs_fault_irq.sv
//==============================================================
// Purpose: Self-checking bench for the fault and status block
// Assumes: Host model on I2C, pull-ups on SDA and interrupt
// Notes: Random values from an LFSR seeded with 30
//==============================================================
`timescale 1ns/1ps
module tb_rfs_fault_irq import rfs_pkg::*; ;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] flt = 5'h00;
	logic [4:0] f;
	logic [7:0] temp_c = 8'h00;
	logic [7:0] ts_a = 8'h00;
	logic [7:0] ts_b = 8'h00;
	logic [7:0] lfsr = 8'h1e;
	logic [7:0] rd_d, en_f, en_i, last_code;
	logic ok;
	logic tx_standby = 1'b0;
	int failures = 0;
	int cmp_count = 0;
	int pkt_cnt = 0;
	int n;
	wire logic scl_w, h_oe, d_oe, d_sda, irq_oe, irq_n, pkt;
	wire logic [7:0] code;
	// Wired-AND bus and interrupt pin
	wire logic sda_w = ~(h_oe | (d_oe & ~d_sda));
	wire logic irq_w = irq_oe ? irq_n : 1'b1;
	rfs_fault_irq i_rfs_fault_irq (.clk_i(clk_i), .rst_n_i(rst_n_i), .disable_i(flt[0]), .charge_done_i(flt[1]),
		.die_shutdown_i(flt[2]), .die_temp_c_i(temp_c), .remote_temp_a_over_i(flt[3]),
		.remote_temp_b_over_i(flt[4]), .remote_temp_input_a_i(ts_a), .remote_temp_input_b_i(ts_b),
		.power_stop_packet_o(pkt), .power_stop_code_o(code), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
		.scl_i(scl_w), .sda_i(sda_w), .sda_o(d_sda), .sda_oe_o(d_oe));
	rfs_host i_rfs_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_oe_o(h_oe));
	// Clock
	initial forever #2.5 clk_i = ~clk_i;
	// Transmitter side: count stop packets, then stand by
	always @(posedge clk_i) begin
		if (pkt === 1'b1) begin
			pkt_cnt <= pkt_cnt + 1;
			last_code <= code;
			tx_standby <= 1'b1;
		end
	end
	function automatic logic [7:0] raw_of(input logic [4:0] v);
		return {v[4], v[3], v[2], 2'b00, v[1], 1'b0, v[0]};
	endfunction
	function automatic logic [7:0] code_of(input logic [4:0] v);
		return (v[4] | v[3]) ? RFS_PKT_THERM : ((v[2] | v[0]) ? RFS_PKT_HEAT : RFS_PKT_DONE);
	endfunction
	function automatic logic [7:0] nxt(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		i_rfs_host.rd(a, rd_d, ok);
		chk("read ack", {7'h00, ok}, 8'h01);
		chk($sformatf("reg %h", a), rd_d, exp);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		i_rfs_host.wr(a, d, ok);
		chk("write ack", {7'h00, ok}, 8'h01);
	endtask
	task automatic setf(input logic [4:0] v, input logic [7:0] t);
		flt <= v;
		temp_c <= t;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (90000) @(posedge clk_i);
		failures++;
		test_done;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rchk(RFS_A_RAW_HI, 8'h00);
		rchk(RFS_A_RAW_LO, 8'h00);
		rchk(RFS_A_PART_HI, RFS_PART_HI_RST);
		rchk(RFS_A_PART_LO, RFS_PART_LO_RST);
		rchk(RFS_A_FEN_LO, RFS_EN_RST & RFS_FAULT_MASK);
		rchk(8'h50, 8'h00);
		wreg(RFS_A_FW, 8'h00);
		rchk(RFS_A_FW, RFS_FW_VALUE);
		wreg(RFS_A_RAW_LO, 8'hff);
		rchk(RFS_A_RAW_LO, 8'h00);
		wreg(RFS_A_PART_HI, 8'ha5);
		rchk(RFS_A_PART_HI, 8'ha5);
		wreg(RFS_A_IEN_LO, 8'h1a);
		rchk(RFS_A_IEN_LO, 8'h00);
		wreg(RFS_A_IEN_LO, 8'he5);
		// Foreign address left unanswered
		i_rfs_host.start;
		i_rfs_host.xfer({7'h69, 1'b0}, 1'b1, rd_d, ok);
		i_rfs_host.stop;
		chk("foreign ack", {7'h00, ok}, 8'h00);
		// Each fault alone
		for (int k = 0; k < 5; k++) begin
			f = 5'h01 << k;
			n = pkt_cnt;
			setf(f, 8'h00);
			chk("irq pin", {7'h00, irq_w}, 8'h00);
			chk("packets", 8'(pkt_cnt - n), 8'h01);
			chk("code", last_code, code_of(f));
			rchk(RFS_A_RAW_LO, raw_of(f));
			rchk(RFS_A_MF_LO, raw_of(f));
			rchk(RFS_A_MI_LO, raw_of(f));
			setf(5'h00, 8'h00);
			chk("irq idle", {7'h00, irq_w}, 8'h01);
		end
		// Die temperature limit edge
		setf(5'h00, RFS_DIE_LIMIT_C - 8'h01);
		rchk(RFS_A_RAW_LO, 8'h00);
		setf(5'h00, RFS_DIE_LIMIT_C);
		rchk(RFS_A_RAW_LO, raw_of(5'h04));
		setf(5'h00, 8'h00);
		// Disabled fault sets raw only
		wreg(RFS_A_FEN_LO, 8'h00);
		wreg(RFS_A_IEN_LO, 8'h00);
		n = pkt_cnt;
		setf(5'h02, 8'h00);
		chk("irq off", {7'h00, irq_w}, 8'h01);
		chk("no packet", 8'(pkt_cnt - n), 8'h00);
		rchk(RFS_A_RAW_LO, raw_of(5'h02));
		rchk(RFS_A_MF_LO, 8'h00);
		setf(5'h00, 8'h00);
		// Random enables, faults and thermistor codes
		repeat (5) begin
			lfsr = nxt(lfsr);
			en_f = lfsr;
			wreg(RFS_A_FEN_LO, en_f);
			lfsr = nxt(lfsr);
			en_i = lfsr;
			wreg(RFS_A_IEN_LO, en_i);
			lfsr = nxt(lfsr);
			ts_a <= lfsr;
			f = lfsr[4:0];
			lfsr = nxt(lfsr);
			ts_b <= lfsr;
			setf(f, 8'h00);
			chk("irq mix", {7'h00, irq_w}, {7'h00, ~|(raw_of(f) & en_i)});
			rchk(RFS_A_RAW_LO, raw_of(f));
			rchk(RFS_A_MF_LO, raw_of(f) & en_f);
			rchk(RFS_A_MI_LO, raw_of(f) & en_i);
			rchk(RFS_A_TS_A, ts_a);
			rchk(RFS_A_TS_B, ts_b);
		end
		chk("tx standby", {7'h00, tx_standby}, 8'h01);
		test_done;
	end
endmodule // tb_rfs_fault_irq
